// File: hw/cps_core.sv
`include "cps_regs.svh"

module cps_core (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [3:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_data_wr,
  input wire logic i_nvm_access,
  input wire logic i_sleep,
  input wire logic i_insn_done,
  input wire logic i_irq_pending,
  input wire logic i_sp_push,
  input wire logic i_sp_pop,
  input wire logic i_sp_call,
  input wire logic i_sp_ret,
  input wire logic i_rf_wr,
  input wire logic [4:0] i_rf_addr,
  input wire logic [7:0] i_rf_wdata,
  input wire logic i_ls_go,
  input wire logic [1:0] i_ls_ptr,
  input wire cps_pkg::cps_amode_e i_ls_mode,
  input wire logic [5:0] i_ls_disp,
  input wire logic i_lpm_go,
  input wire logic i_lpm_inc,
  input wire logic [3:0] i_dbg_en,
  input wire logic i_pc_match,
  input wire logic i_flow_change,
  input wire logic i_brk_insn,
  output logic [7:0] o_io_rdata,
  output logic o_io_unlock,
  output logic o_spm_unlock,
  output logic o_irq_hold,
  output logic o_irq_service,
  output logic [15:0] o_stack_pointer,
  output logic [7:0] o_status_flags,
  output logic [15:0] o_ptr_addr,
  output logic [15:0] o_pm_addr,
  output logic o_dbg_halt
);
  import cps_pkg::*;

  cps_core_s s;
  cps_core_s next_s;
  logic [15:0] ptr_val [`CPS_PTR_COUNT];
  logic key_wr;
  logic sp_lo_wr;
  logic sp_hi_wr;
  logic flags_wr;
  logic io_close;
  logic spm_close;

  assign key_wr = i_io_wr && (i_io_addr == `CPS_OFS_KEY);
  assign sp_lo_wr = i_io_wr && (i_io_addr == `CPS_OFS_SP_LO);
  assign sp_hi_wr = i_io_wr && (i_io_addr == `CPS_OFS_SP_HI);
  assign flags_wr = i_io_wr && (i_io_addr == `CPS_OFS_FLAGS);
  // The protected write itself is an I/O write, so it also ends the window
  assign io_close = i_io_wr || i_data_wr || i_nvm_access || i_sleep;
  assign spm_close = i_nvm_access || i_sleep;

  genvar k;
  generate
    for (k = 0; k < `CPS_PTR_COUNT; k = k + 1) begin : g_ptr
      logic sel;
      logic wr_lo;
      logic wr_hi;
      logic inc;
      logic dec;
      assign sel = i_ls_go && (i_ls_ptr == 2'(k));
      // Each pair is two adjacent upper working registers
      assign wr_lo = i_rf_wr && (i_rf_addr == 5'(`CPS_RF_PTR_BASE + 2 * k));
      assign wr_hi = i_rf_wr && (i_rf_addr == 5'(`CPS_RF_PTR_BASE + 2 * k + 1));
      assign inc = (sel && (i_ls_mode == CPS_AM_POSTINC)) ||
                   ((2'(k) == `CPS_PTR_THIRD) && i_lpm_go && i_lpm_inc);
      assign dec = sel && (i_ls_mode == CPS_AM_PREDEC);
      cps_ptr u_ptr (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_wr_lo(wr_lo),
        .i_wr_hi(wr_hi),
        .i_wdata(i_rf_wdata),
        .i_inc(inc),
        .i_dec(dec),
        .o_value(ptr_val[k])
      );
    end
  endgenerate

  always_comb begin
    logic [15:0] base;
    base = 16'h0000;
    next_s = s;

    // Unlock window
    if (s.win != CPS_LOCKED && i_insn_done) begin
      next_s.win_cnt = s.win_cnt - 3'h1;
      if (s.win_cnt == 3'h1) begin
        next_s.win = CPS_LOCKED;
      end
    end
    unique case (s.win)
      CPS_LOCKED: begin
      end
      CPS_OPEN_IO: begin
        if (io_close) begin
          next_s.win = CPS_LOCKED;
        end
      end
      CPS_OPEN_SPM: begin
        if (spm_close) begin
          next_s.win = CPS_LOCKED;
        end
      end
      default: begin
        next_s.win = CPS_LOCKED;
      end
    endcase
    // The key-writing instruction is not counted in the window
    if (key_wr) begin
      if (i_io_wdata == `CPS_KEY_IO) begin
        next_s.win = CPS_OPEN_IO;
        next_s.win_cnt = `CPS_WIN_INSNS;
      end else if (i_io_wdata == `CPS_KEY_SPM) begin
        next_s.win = CPS_OPEN_SPM;
        next_s.win_cnt = `CPS_WIN_INSNS;
      end
      // Any other value opens no window
    end
    if (next_s.win == CPS_LOCKED) begin
      next_s.win_cnt = 3'h0;
    end

    // Interrupt hold after a stack low byte write
    if (sp_lo_wr) begin
      next_s.sp_cnt = `CPS_SP_HOLD_INSNS;
    end else if (s.sp_cnt != 3'h0) begin
      if (i_io_wr) begin
        next_s.sp_cnt = 3'h0;
      end else if (i_insn_done) begin
        next_s.sp_cnt = s.sp_cnt - 3'h1;
      end
    end

    // Requests outside stay pending while held; service follows release
    next_s.irq_hold = (next_s.win != CPS_LOCKED) || (next_s.sp_cnt != 3'h0);
    next_s.irq_service = i_irq_pending && s.flags[`CPS_FLAGS_BIT_IE] &&
                         !next_s.irq_hold;

    // Stack pointer: software write has priority over hardware steps
    if (sp_lo_wr || sp_hi_wr) begin
      if (sp_lo_wr) begin
        next_s.sp[7:0] = i_io_wdata;
      end
      if (sp_hi_wr) begin
        next_s.sp[15:8] = i_io_wdata;
      end
    end else if (i_sp_call) begin
      next_s.sp = s.sp - `CPS_SP_STEP_WORD;
    end else if (i_sp_ret) begin
      next_s.sp = s.sp + `CPS_SP_STEP_WORD;
    end else if (i_sp_push) begin
      next_s.sp = s.sp - `CPS_SP_STEP_BYTE;
    end else if (i_sp_pop) begin
      next_s.sp = s.sp + `CPS_SP_STEP_BYTE;
    end
    next_s.sp = next_s.sp & `CPS_SP_MASK;

    if (flags_wr) begin
      next_s.flags = i_io_wdata;
    end

    // Register read-back, unmapped offsets answer zero
    if (i_io_rd) begin
      unique case (i_io_addr)
        `CPS_OFS_KEY: begin
          next_s.rdata = 8'h00;
          next_s.rdata[`CPS_KEY_BIT_IO] = (s.win == CPS_OPEN_IO);
          next_s.rdata[`CPS_KEY_BIT_SPM] = (s.win == CPS_OPEN_SPM);
        end
        `CPS_OFS_SP_LO: begin
          next_s.rdata = s.sp[7:0];
        end
        `CPS_OFS_SP_HI: begin
          next_s.rdata = s.sp[15:8];
        end
        `CPS_OFS_FLAGS: begin
          next_s.rdata = s.flags;
        end
        default: begin
          next_s.rdata = 8'h00;
        end
      endcase
    end

    // Data memory address from the chosen pointer
    if (i_ls_go) begin
      if (i_ls_ptr == 2'h0) begin
        base = ptr_val[0];
      end else if (i_ls_ptr == 2'h1) begin
        base = ptr_val[1];
      end else begin
        base = ptr_val[2];
      end
      unique case (i_ls_mode)
        CPS_AM_DISP: begin
          next_s.ptr_addr = base + {10'h000, i_ls_disp};
        end
        CPS_AM_POSTINC: begin
          next_s.ptr_addr = base;
        end
        CPS_AM_PREDEC: begin
          next_s.ptr_addr = base - 16'h0001;
        end
        default: begin
          next_s.ptr_addr = base;
        end
      endcase
    end
    if (i_lpm_go) begin
      next_s.pm_addr = ptr_val[2];
    end

    next_s.dbg_halt = |(i_dbg_en &
                        {i_brk_insn, s.irq_service, i_flow_change, i_pc_match});
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s <= '0;
      s.win <= CPS_LOCKED;
      s.sp <= `CPS_SP_RESET;
      s.flags <= `CPS_FLAGS_RESET;
      s.rdata <= `CPS_KEY_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Protected registers and the NVM command port gate on these levels
  // Window codes are one-hot, so each unlock level is a state flop bit
  assign o_io_unlock = s.win[`CPS_KEY_BIT_IO];
  assign o_spm_unlock = s.win[`CPS_KEY_BIT_SPM];
  assign o_io_rdata = s.rdata;
  assign o_irq_hold = s.irq_hold;
  assign o_irq_service = s.irq_service;
  assign o_stack_pointer = s.sp;
  assign o_status_flags = s.flags;
  assign o_ptr_addr = s.ptr_addr;
  assign o_pm_addr = s.pm_addr;
  assign o_dbg_halt = s.dbg_halt;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  key_io_open_a: assert property (key_wr && i_io_wdata == `CPS_KEY_IO |=> o_io_unlock)
    else $error("I/O key did not open the window");
  key_spm_open_a: assert property (key_wr && i_io_wdata == `CPS_KEY_SPM |=>
                                   o_spm_unlock && !o_io_unlock)
    else $error("self-program key did not open the window");
  bad_key_a: assert property (key_wr && i_io_wdata != `CPS_KEY_IO &&
                              i_io_wdata != `CPS_KEY_SPM |=>
                              !o_io_unlock && !o_spm_unlock)
    else $error("unknown key left a window open");
  window_end_a: assert property ((o_io_unlock || o_spm_unlock) && s.win_cnt == 3'h1 &&
                                 i_insn_done && !key_wr |=>
                                 !o_io_unlock && !o_spm_unlock)
    else $error("window outlived four instructions");
  io_close_a: assert property (o_io_unlock && io_close && !key_wr |=> !o_io_unlock)
    else $error("I/O window not closed by a closing event");
  spm_close_a: assert property (o_spm_unlock && spm_close && !key_wr |=> !o_spm_unlock)
    else $error("self-program window not closed by a closing event");
  hold_window_a: assert property ((o_io_unlock || o_spm_unlock) |->
                                  o_irq_hold && !o_irq_service)
    else $error("interrupt serviced inside the unlock window");
  service_after_a: assert property ($fell(o_irq_hold) && $past(i_irq_pending) &&
                                    $past(s.flags[`CPS_FLAGS_BIT_IE]) |-> o_irq_service)
    else $error("pending interrupt not serviced after release");
  key_read_a: assert property (i_io_rd && i_io_addr == `CPS_OFS_KEY |=>
                               o_io_rdata[7:2] == 6'h00 &&
                               o_io_rdata[0] == $past(o_io_unlock) &&
                               o_io_rdata[1] == $past(o_spm_unlock))
    else $error("key register read-back wrong");
  sp_reset_a: assert property ($past(i_rst) |-> o_stack_pointer == `CPS_SP_RESET)
    else $error("stack pointer not at top of SRAM after reset");
  sp_mask_a: assert property ((o_stack_pointer & ~`CPS_SP_MASK) == 16'h0000)
    else $error("unimplemented stack pointer bit set");
  sp_call_a: assert property (i_sp_call && !sp_lo_wr && !sp_hi_wr |=>
                              o_stack_pointer == (($past(o_stack_pointer) -
                              `CPS_SP_STEP_WORD) & `CPS_SP_MASK))
    else $error("call did not lower the stack pointer by two");
  sp_hold_a: assert property (sp_lo_wr |=> o_irq_hold [*1] ##0 s.sp_cnt == `CPS_SP_HOLD_INSNS)
    else $error("stack low write did not hold interrupts");
  predec_addr_a: assert property (i_ls_go && i_ls_mode == CPS_AM_PREDEC && i_ls_ptr == 2'h0 |=>
                                  o_ptr_addr == $past(ptr_val[0]) - 16'h0001)
    else $error("pre-decrement address wrong");

endmodule

// File: hw/cps_ptr.sv
`include "cps_regs.svh"

module cps_ptr (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic [7:0] i_wdata,
  input wire logic i_inc,
  input wire logic i_dec,
  output logic [15:0] o_value
);
  import cps_pkg::*;

  cps_ptr_s s;
  cps_ptr_s next_s;

  always_comb begin
    next_s = s;
    if (i_inc) begin
      next_s.value = s.value + 16'h0001;
    end else if (i_dec) begin
      next_s.value = s.value - 16'h0001;
    end
    // A register file write in the same cycle wins over the step
    if (i_wr_lo) begin
      next_s.value[7:0] = i_wdata;
    end
    if (i_wr_hi) begin
      next_s.value[15:8] = i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_value = s.value;

endmodule

// File: pkg/cps_pkg.sv
package cps_pkg;

  typedef enum logic [1:0] {
    CPS_LOCKED = 2'b00,
    CPS_OPEN_IO = 2'b01,
    CPS_OPEN_SPM = 2'b10
  } cps_win_e;

  typedef enum logic [1:0] {
    CPS_AM_DISP = 2'b00,
    CPS_AM_POSTINC = 2'b01,
    CPS_AM_PREDEC = 2'b10
  } cps_amode_e;

  typedef struct packed {
    cps_win_e win;
    logic [2:0] win_cnt;
    logic [2:0] sp_cnt;
    logic irq_hold;
    logic irq_service;
    logic dbg_halt;
    logic [15:0] sp;
    logic [7:0] flags;
    logic [7:0] rdata;
    logic [15:0] ptr_addr;
    logic [15:0] pm_addr;
  } cps_core_s;

  typedef struct packed {
    logic [15:0] value;
  } cps_ptr_s;

endpackage

// File: pkg/cps_regs.svh
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH

// I/O offsets inside the CPU register block
`define CPS_OFS_KEY 4'h4
`define CPS_OFS_SP_LO 4'hd
`define CPS_OFS_SP_HI 4'he
`define CPS_OFS_FLAGS 4'hf

// Key values
`define CPS_KEY_SPM 8'h9d
`define CPS_KEY_IO 8'hd8

// Key register read-back bit positions
`define CPS_KEY_BIT_IO 0
`define CPS_KEY_BIT_SPM 1

// Reset values, stack pointer mask and interrupt enable bit
`define CPS_KEY_RESET 8'h00
`define CPS_FLAGS_RESET 8'h00
`define CPS_SP_RESET 16'h3fff
`define CPS_SP_MASK 16'h3fff
`define CPS_FLAGS_BIT_IE 7

// Instruction counts
`define CPS_WIN_INSNS 3'h4
`define CPS_SP_HOLD_INSNS 3'h4

// Stack steps
`define CPS_SP_STEP_BYTE 16'h0001
`define CPS_SP_STEP_WORD 16'h0002

// Working register number of the first pointer low byte
`define CPS_RF_PTR_BASE 5'h1a
`define CPS_PTR_COUNT 3
`define CPS_PTR_THIRD 2'h2

`endif

// File: tb/test_cpu_protect_and_stack_regs.sv
`include "cps_regs.svh"

module test_cpu_protect_and_stack_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import cps_pkg::*;

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t got %h expected %h", $time, g, e); end end

  localparam int ev_dwr = 0, ev_nvm = 1, ev_slp = 2, ev_insn = 3, ev_push = 4, ev_pop = 5;
  localparam int ev_call = 6, ev_ret = 7, ev_ls = 8, ev_lpm = 9;
  int checks = 0, err_count = 0, cycles = 0;
  logic i_clock = 1'b0, i_rst = 1'b1, i_io_wr = 1'b0, i_io_rd = 1'b0;
  logic [3:0] i_io_addr = 4'h0, i_dbg_en = 4'h0;
  logic [7:0] i_io_wdata = 8'h00, i_rf_wdata = 8'h00, rd;
  logic [12:0] ev = 13'h0000;
  logic i_irq_pending = 1'b0, i_rf_wr = 1'b0, i_lpm_inc = 1'b0;
  logic [4:0] i_rf_addr = 5'h00;
  logic [1:0] i_ls_ptr = 2'h0;
  cps_amode_e i_ls_mode = CPS_AM_DISP;
  logic [5:0] i_ls_disp = 6'h00;
  logic [7:0] o_io_rdata, o_status_flags;
  logic o_io_unlock, o_spm_unlock, o_irq_hold, o_irq_service, o_dbg_halt;
  logic [15:0] o_stack_pointer, o_ptr_addr, o_pm_addr;

  cps_core dut (.i_clock, .i_rst, .i_io_wr, .i_io_rd, .i_io_addr, .i_io_wdata,
    .i_data_wr(ev[0]), .i_nvm_access(ev[1]), .i_sleep(ev[2]), .i_insn_done(ev[3]),
    .i_irq_pending, .i_sp_push(ev[4]), .i_sp_pop(ev[5]), .i_sp_call(ev[6]),
    .i_sp_ret(ev[7]), .i_rf_wr, .i_rf_addr, .i_rf_wdata, .i_ls_go(ev[8]), .i_ls_ptr,
    .i_ls_mode, .i_ls_disp, .i_lpm_go(ev[9]), .i_lpm_inc, .i_dbg_en,
    .i_pc_match(ev[10]), .i_flow_change(ev[11]), .i_brk_insn(ev[12]), .o_io_rdata,
    .o_io_unlock, .o_spm_unlock, .o_irq_hold, .o_irq_service, .o_stack_pointer,
    .o_status_flags, .o_ptr_addr, .o_pm_addr, .o_dbg_halt);

  always #10 i_clock = ~i_clock;

  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic step;
    @(posedge i_clock);
    #1;
  endtask

  task automatic pulse(input int k);
    @(posedge i_clock);
    ev[k] <= 1'b1;
    @(posedge i_clock);
    ev[k] <= 1'b0;
    #1;
  endtask

  task automatic io_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_io_wr <= 1'b1;
    i_io_addr <= a;
    i_io_wdata <= d;
    @(posedge i_clock);
    i_io_wr <= 1'b0;
    #1;
  endtask

  task automatic io_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_io_rd <= 1'b1;
    i_io_addr <= a;
    @(posedge i_clock);
    i_io_rd <= 1'b0;
    step();
    d = o_io_rdata;
  endtask

  task automatic rf(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_rf_wr <= 1'b1;
    i_rf_addr <= a;
    i_rf_wdata <= d;
    @(posedge i_clock);
    i_rf_wr <= 1'b0;
    #1;
  endtask

  task automatic ls(input logic [1:0] p, input cps_amode_e m, input logic [5:0] dsp);
    @(posedge i_clock);
    i_ls_ptr <= p;
    i_ls_mode <= m;
    i_ls_disp <= dsp;
    pulse(ev_ls);
  endtask

  task automatic t_reset;
    `CHK(o_stack_pointer, 16'h3fff)
    io_rd(`CPS_OFS_SP_HI, rd);
    `CHK(rd, 8'h3f)
    io_rd(`CPS_OFS_SP_LO, rd);
    `CHK(rd, 8'hff)
    io_rd(`CPS_OFS_KEY, rd);
    `CHK(rd, 8'h00)
    io_rd(4'h0, rd);
    `CHK(rd, 8'h00)
  endtask

  // Interrupt already pending before the window is held inside it and serviced after its end
  task automatic t_io_window;
    io_wr(`CPS_OFS_FLAGS, 8'h80);
    `CHK(o_status_flags, 8'h80)
    i_irq_pending <= 1'b1;
    step();
    `CHK(o_irq_service, 1'b1)
    io_wr(`CPS_OFS_KEY, `CPS_KEY_IO);
    step();
    `CHK(o_io_unlock, 1'b1)
    `CHK({o_irq_hold, o_irq_service}, 2'b10)
    io_rd(`CPS_OFS_KEY, rd);
    `CHK(rd, 8'h01)
    repeat (3) pulse(ev_insn);
    `CHK(o_io_unlock, 1'b1)
    pulse(ev_insn);
    step();
    `CHK(o_io_unlock, 1'b0)
    `CHK({o_irq_hold, o_irq_service}, 2'b01)
    i_irq_pending <= 1'b0;
  endtask

  task automatic t_spm;
    io_wr(`CPS_OFS_KEY, `CPS_KEY_SPM);
    step();
    `CHK({o_spm_unlock, o_io_unlock}, 2'b10)
    io_rd(`CPS_OFS_KEY, rd);
    `CHK(rd, 8'h02)
    pulse(ev_dwr);
    step();
    `CHK(o_spm_unlock, 1'b1)
    for (int k = ev_nvm; k <= ev_slp; k++) begin
      if (k == ev_slp) io_wr(`CPS_OFS_KEY, `CPS_KEY_SPM);
      pulse(k);
      step();
      `CHK(o_spm_unlock, 1'b0)
    end
  endtask

  task automatic t_io_close;
    for (int k = ev_dwr; k <= ev_slp; k++) begin
      io_wr(`CPS_OFS_KEY, `CPS_KEY_IO);
      pulse(k);
      step();
      `CHK(o_io_unlock, 1'b0)
    end
    io_wr(`CPS_OFS_KEY, `CPS_KEY_IO);
    `CHK(o_io_unlock, 1'b1)
    io_wr(`CPS_OFS_FLAGS, 8'h00);
    step();
    `CHK(o_status_flags, 8'h00)
    `CHK(o_io_unlock, 1'b0)
  endtask

  task automatic t_bad_key;
    io_wr(`CPS_OFS_KEY, 8'h55);
    step();
    `CHK({o_io_unlock, o_spm_unlock, o_irq_hold}, 3'b000)
    io_rd(`CPS_OFS_KEY, rd);
    `CHK(rd, 8'h00)
  endtask

  task automatic t_sp;
    io_wr(`CPS_OFS_SP_LO, 8'h34);
    step();
    `CHK(o_irq_hold, 1'b1)
    io_wr(`CPS_OFS_SP_HI, 8'hff);
    step();
    `CHK(o_irq_hold, 1'b0)
    `CHK(o_stack_pointer, 16'h3f34)
    io_wr(`CPS_OFS_SP_LO, 8'h40);
    repeat (3) pulse(ev_insn);
    `CHK(o_irq_hold, 1'b1)
    pulse(ev_insn);
    step();
    `CHK(o_irq_hold, 1'b0)
    pulse(ev_call);
    `CHK(o_stack_pointer, 16'h3f3e)
    pulse(ev_ret);
    `CHK(o_stack_pointer, 16'h3f40)
    pulse(ev_push);
    `CHK(o_stack_pointer, 16'h3f3f)
    pulse(ev_pop);
    `CHK(o_stack_pointer, 16'h3f40)
  endtask

  task automatic t_ptr;
    rf(5'h1a, 8'h10);
    rf(5'h1b, 8'h20);
    ls(2'h0, CPS_AM_DISP, 6'h05);
    `CHK(o_ptr_addr, 16'h2015)
    ls(2'h0, CPS_AM_POSTINC, 6'h00);
    `CHK(o_ptr_addr, 16'h2010)
    ls(2'h0, CPS_AM_PREDEC, 6'h00);
    `CHK(o_ptr_addr, 16'h2010)
    rf(5'h1d, 8'h0a);
    ls(2'h1, CPS_AM_DISP, 6'h3f);
    `CHK(o_ptr_addr, 16'h0a3f)
    rf(5'h1e, 8'hff);
    rf(5'h1f, 8'h01);
    i_lpm_inc <= 1'b1;
    pulse(ev_lpm);
    `CHK(o_pm_addr, 16'h01ff)
    pulse(ev_lpm);
    `CHK(o_pm_addr, 16'h0200)
    ls(2'h2, CPS_AM_DISP, 6'h00);
    `CHK(o_ptr_addr, 16'h0201)
  endtask

  task automatic t_dbg;
    for (int k = 0; k < 3; k++) begin
      i_dbg_en <= 4'h0;
      pulse(10 + k);
      `CHK(o_dbg_halt, 1'b0)
      i_dbg_en <= (k == 2) ? 4'h8 : 4'(1 << k);
      pulse(10 + k);
      `CHK(o_dbg_halt, 1'b1)
      step();
    end
    // Interrupt breakpoint follows the registered service level
    io_wr(`CPS_OFS_FLAGS, 8'h80);
    i_dbg_en <= 4'h4;
    i_irq_pending <= 1'b1;
    repeat (2) step();
    `CHK(o_dbg_halt, 1'b1)
    i_irq_pending <= 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    step();
    t_reset();
    t_io_window();
    t_spm();
    t_io_close();
    t_bad_key();
    t_sp();
    t_ptr();
    t_dbg();
    close_out();
  end
endmodule
